// ==== src/cspc_top.sv ====
// Socket power control register bank with layout selection and power requests.
// Assumes a byte register port from the socket register decoder, synchronous to core_clk.
`timescale 1ns/100ps
module cspc_top
    import cspc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    input wire logic sysctrl_supply_gate,
    input wire logic card_detect1_b,
    input wire logic card_detect2_b,
    output logic card_output_enable_r,
    output cspc_pwr_t pwr_req_r,
    output logic [7:0] int_gen_ctrl_r
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic cspc_is_legacy(input logic [7:0] id_rev);
        cspc_is_legacy = (id_rev[CSPC_ID_REV_MSB:CSPC_ID_REV_LSB] == CSPC_REV_LEGACY);
    endfunction : cspc_is_legacy

    function automatic logic cspc_addr_hit(input logic [11:0] addr, input logic [11:0] ofs);
        cspc_addr_hit = (addr == ofs);
    endfunction : cspc_addr_hit

    function automatic logic [7:0] cspc_power_view(input logic legacy,
                                                   input cspc_fields_t f);
        logic [7:0] v;
        v = 8'h00;
        v[CSPC_PWR_OE_BIT] = f.card_output_enable;
        v[CSPC_PWR_VPP_MSB:CSPC_PWR_VPP_LSB] = f.prog_voltage_request;
        if (legacy) begin
            v[CSPC_PWR_AUTO_BIT] = f.auto_switch_enable;
            v[CSPC_PWR_CAPEN_BIT] = f.card_power_enable;
        end else begin
            v[CSPC_PWR_VCC_MSB:CSPC_PWR_VCC_LSB] = f.supply_voltage_request;
        end
        cspc_power_view = v;
    endfunction : cspc_power_view

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic sel_id;
    logic sel_pwr;
    logic sel_int;
    logic wr_id;
    logic wr_pwr;
    logic legacy;
    logic card_present;
    logic [7:0] id_rev_r;
    logic oe_bit_r;
    logic auto_sw_r;
    logic cap_pwr_r;
    logic [1:0] vcc_req_r;
    logic [1:0] vpp_req_r;
    cspc_fields_t fields;
    cspc_pwr_t pwr_nxt;
    logic [7:0] rdata_nxt;

    assign sel_id = cspc_addr_hit(reg_addr, CSPC_OFS_ID_REV);
    assign sel_pwr = cspc_addr_hit(reg_addr, CSPC_OFS_POWER);
    assign sel_int = cspc_addr_hit(reg_addr, CSPC_OFS_INT_GEN);
    assign wr_id = reg_wr && sel_id;
    assign wr_pwr = reg_wr && sel_pwr;
    assign card_present = !card_detect1_b && !card_detect2_b;

    // ------------------------------------------------------------------
    // Layout select
    // ------------------------------------------------------------------
    assign legacy = cspc_is_legacy(id_rev_r);

    // ------------------------------------------------------------------
    // Identification and revision register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            id_rev_r <= CSPC_RST_ID_REV;
        end else if (wr_id) begin
            id_rev_r[CSPC_ID_RW_MSB:0] <= reg_wdata[CSPC_ID_RW_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // Power control, output enable in both layouts
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_bit_r <= CSPC_FIELDS_RST.card_output_enable;
        end else if (wr_pwr) begin
            oe_bit_r <= reg_wdata[CSPC_PWR_OE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Power control, programming voltage request in both layouts
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vpp_req_r <= CSPC_FIELDS_RST.prog_voltage_request;
        end else if (wr_pwr) begin
            vpp_req_r <= reg_wdata[CSPC_PWR_VPP_MSB:CSPC_PWR_VPP_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Power control, legacy switch fields
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            auto_sw_r <= CSPC_FIELDS_RST.auto_switch_enable;
            cap_pwr_r <= CSPC_FIELDS_RST.card_power_enable;
        end else if (wr_pwr && legacy) begin
            auto_sw_r <= reg_wdata[CSPC_PWR_AUTO_BIT];
            cap_pwr_r <= reg_wdata[CSPC_PWR_CAPEN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Power control, extended supply request
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vcc_req_r <= CSPC_FIELDS_RST.supply_voltage_request;
        end else if (wr_pwr && !legacy) begin
            vcc_req_r <= reg_wdata[CSPC_PWR_VCC_MSB:CSPC_PWR_VCC_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Stored fields, reserved bits hold no state
    // ------------------------------------------------------------------
    assign fields = '{
        card_output_enable: oe_bit_r,
        auto_switch_enable: auto_sw_r,
        card_power_enable: cap_pwr_r,
        supply_voltage_request: vcc_req_r,
        prog_voltage_request: vpp_req_r
    };

    // ------------------------------------------------------------------
    // Interrupt and general control register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_gen_ctrl_r <= CSPC_RST_INT_GEN;
        end else if (reg_wr && sel_int) begin
            int_gen_ctrl_r <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Socket outputs
    // ------------------------------------------------------------------
    cspc_decode u_decode (
        .legacy(legacy),
        .fields(fields),
        .sysctrl_supply_gate(sysctrl_supply_gate),
        .card_present(card_present),
        .pwr(pwr_nxt)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            card_output_enable_r <= 1'h0;
        end else begin
            card_output_enable_r <= fields.card_output_enable;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_req_r <= '{CSPC_VCC_OFF, CSPC_VPP_OFF};
        end else begin
            pwr_req_r <= pwr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (sel_id) begin
            rdata_nxt = id_rev_r;
        end else if (sel_pwr) begin
            rdata_nxt = cspc_power_view(legacy, fields);
        end else if (sel_int) begin
            rdata_nxt = int_gen_ctrl_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

endmodule : cspc_top

// ==== src/cspc_pkg.sv ====
// Constants, field layouts and carrier types for the socket power control block.
// Assumes byte-wide register accesses within the socket register window.
package cspc_pkg;

    // ------------------------------------------------------------------
    // Register offsets within the socket register space
    // ------------------------------------------------------------------
    localparam logic [11:0] CSPC_OFS_ID_REV = 12'h800;
    localparam logic [11:0] CSPC_OFS_POWER = 12'h802;
    localparam logic [11:0] CSPC_OFS_INT_GEN = 12'h803;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CSPC_RST_ID_REV = 8'h84;
    localparam logic [7:0] CSPC_RST_POWER = 8'h00;
    localparam logic [7:0] CSPC_RST_INT_GEN = 8'h00;

    // ------------------------------------------------------------------
    // Identification register fields
    // ------------------------------------------------------------------
    localparam int CSPC_ID_IFTYPE_MSB = 7;
    localparam int CSPC_ID_IFTYPE_LSB = 6;
    localparam int CSPC_ID_RW_MSB = 5;
    localparam int CSPC_ID_REV_MSB = 3;
    localparam int CSPC_ID_REV_LSB = 0;
    localparam logic [3:0] CSPC_REV_LEGACY = 4'h2;

    // ------------------------------------------------------------------
    // Power control fields
    // ------------------------------------------------------------------
    localparam int CSPC_PWR_OE_BIT = 7;
    localparam int CSPC_PWR_AUTO_BIT = 5;
    localparam int CSPC_PWR_CAPEN_BIT = 4;
    localparam int CSPC_PWR_VCC_MSB = 4;
    localparam int CSPC_PWR_VCC_LSB = 3;
    localparam int CSPC_PWR_VPP_MSB = 1;
    localparam int CSPC_PWR_VPP_LSB = 0;

    // Programming voltage request codes
    localparam logic [1:0] CSPC_VPP_REQ_NONE = 2'h0;
    localparam logic [1:0] CSPC_VPP_REQ_VCC = 2'h1;
    localparam logic [1:0] CSPC_VPP_REQ_12V = 2'h2;
    localparam logic [1:0] CSPC_VPP_REQ_RSVD = 2'h3;

    // Supply voltage request codes
    localparam logic [1:0] CSPC_VCC_REQ_0V = 2'h0;
    localparam logic [1:0] CSPC_VCC_REQ_0V_RSVD = 2'h1;
    localparam logic [1:0] CSPC_VCC_REQ_5V = 2'h2;
    localparam logic [1:0] CSPC_VCC_REQ_3V3 = 2'h3;

    // ------------------------------------------------------------------
    // Power switch request toward the socket
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CSPC_VCC_OFF = 2'h0,
        CSPC_VCC_5V = 2'h1,
        CSPC_VCC_3V3 = 2'h2
    } cspc_vcc_t;

    typedef enum logic [1:0] {
        CSPC_VPP_OFF = 2'h0,
        CSPC_VPP_VCC = 2'h1,
        CSPC_VPP_12V = 2'h2
    } cspc_vpp_t;

    typedef struct packed {
        cspc_vcc_t vcc;
        cspc_vpp_t vpp;
    } cspc_pwr_t;

    // Stored power control fields, both layouts
    typedef struct packed {
        logic card_output_enable;
        logic auto_switch_enable;
        logic card_power_enable;
        logic [1:0] supply_voltage_request;
        logic [1:0] prog_voltage_request;
    } cspc_fields_t;

    localparam cspc_fields_t CSPC_FIELDS_RST = '{1'h0, 1'h0, 1'h0, 2'h0, 2'h0};

endpackage : cspc_pkg

// ==== src/cspc_decode.sv ====
// Power switch decode from the stored power control fields.
// Assumes card detect and supply gate inputs are synchronous to core_clk.
`timescale 1ns/100ps
module cspc_decode
    import cspc_pkg::*;
(
    input wire logic legacy,
    input wire cspc_fields_t fields,
    input wire logic sysctrl_supply_gate,
    input wire logic card_present,
    output cspc_pwr_t pwr
);

    // ------------------------------------------------------------------
    // Supply and programming voltage decode
    // ------------------------------------------------------------------
    always_comb begin
        pwr.vcc = CSPC_VCC_OFF;
        pwr.vpp = CSPC_VPP_OFF;
        if (legacy) begin
            if (fields.card_power_enable && sysctrl_supply_gate &&
                (!fields.auto_switch_enable || card_present)) begin
                pwr.vcc = CSPC_VCC_5V;
            end
        end else begin
            unique case (fields.supply_voltage_request)
                CSPC_VCC_REQ_0V: pwr.vcc = CSPC_VCC_OFF;
                CSPC_VCC_REQ_0V_RSVD: pwr.vcc = CSPC_VCC_OFF;
                CSPC_VCC_REQ_5V: pwr.vcc = CSPC_VCC_5V;
                CSPC_VCC_REQ_3V3: pwr.vcc = CSPC_VCC_3V3;
            endcase
        end
        if (pwr.vcc != CSPC_VCC_OFF) begin
            unique case (fields.prog_voltage_request)
                CSPC_VPP_REQ_NONE: pwr.vpp = CSPC_VPP_OFF;
                CSPC_VPP_REQ_VCC: pwr.vpp = CSPC_VPP_VCC;
                CSPC_VPP_REQ_12V: pwr.vpp = CSPC_VPP_12V;
                CSPC_VPP_REQ_RSVD: pwr.vpp = CSPC_VPP_OFF;
            endcase
        end
    end

endmodule : cspc_decode

// ==== tb/cspc_sva.sv ====
// Port checker for the socket power control block.
// Assumes one core_clk domain; bound to cspc_top below.
`timescale 1ns/100ps
module cspc_sva
    import cspc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic card_detect1_b,
    input wire cspc_pwr_t pwr_req_r,
    input wire logic card_output_enable_r,
    input wire logic [7:0] int_gen_ctrl_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [3:0] rev_r;
    logic legacy;
    logic pw;
    logic rdp;
    // --------------------------------------------------------------
    // Layout tracking
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rev_r <= 4'h4;
        end else if (reg_wr && reg_addr == CSPC_OFS_ID_REV) begin
            rev_r <= reg_wdata[3:0];
        end
    end
    assign legacy = (rev_r == CSPC_REV_LEGACY);
    assign pw = reg_wr && reg_addr == CSPC_OFS_POWER;
    assign rdp = reg_rd && reg_addr == CSPC_OFS_POWER;
    sequence s_ext_wr(logic [1:0] v);
        pw && !legacy && reg_wdata[4:3] == v;
    endsequence
    sequence s_leg_wr;
        pw && legacy;
    endsequence
    a_oe_follows: assert property (pw |-> ##2 card_output_enable_r == $past(reg_wdata[7], 2))
        else $error("output enable mismatch");
    a_leg_rdzero: assert property (rdp && legacy |=> reg_rdata_r[6] == 1'b0 && reg_rdata_r[3:2] == 2'h0)
        else $error("legacy reserved bits not zero");
    a_ext_rdzero: assert property (rdp && !legacy |=> reg_rdata_r[6:5] == 2'h0 && !reg_rdata_r[2])
        else $error("extended reserved bits not zero");
    a_vcc_off: assert property (s_ext_wr(2'h0) |-> ##2 pwr_req_r.vcc == CSPC_VCC_OFF)
        else $error("supply not off");
    a_vcc_five: assert property (s_ext_wr(2'h2) |-> ##2 pwr_req_r.vcc == CSPC_VCC_5V)
        else $error("supply not 5V");
    a_vcc_three: assert property (s_ext_wr(2'h3) |-> ##2 pwr_req_r.vcc == CSPC_VCC_3V3)
        else $error("supply not 3.3V");
    a_vpp_code: assert property (s_ext_wr(2'h2) ##0 reg_wdata[1:0] == 2'h1 |-> ##2 pwr_req_r.vpp == CSPC_VPP_VCC)
        else $error("vpp not Vcc");
    a_vpp_gated: assert property (pwr_req_r.vcc == CSPC_VCC_OFF |-> pwr_req_r.vpp == CSPC_VPP_OFF)
        else $error("vpp without supply");
    a_leg_nocap: assert property (s_leg_wr ##0 !reg_wdata[4] |-> ##2 pwr_req_r.vcc == CSPC_VCC_OFF)
        else $error("legacy supply on without enable");
    a_auto_nocard: assert property (s_leg_wr ##0 reg_wdata[5] && card_detect1_b |-> ##2 pwr_req_r.vcc == CSPC_VCC_OFF)
        else $error("auto switch powered empty socket");
    a_intgen_wr: assert property (reg_wr && reg_addr == CSPC_OFS_INT_GEN |=> int_gen_ctrl_r == $past(reg_wdata))
        else $error("int gen write lost");
endmodule : cspc_sva
bind cspc_top cspc_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .card_detect1_b(card_detect1_b), .pwr_req_r(pwr_req_r),
    .card_output_enable_r(card_output_enable_r), .int_gen_ctrl_r(int_gen_ctrl_r));

// ==== tb/cspc_socket_model.sv ====
// Socket model: card detect pins from a card insertion level.
// Assumes the bench changes card_in well away from clock edges.
`timescale 1ns/100ps
module cspc_socket_model (
    input wire logic card_in,
    output logic card_detect1_b,
    output logic card_detect2_b
);
    // Second detect pin seats a little after the first
    assign card_detect1_b = !card_in;
    assign #3 card_detect2_b = !card_in;
endmodule : cspc_socket_model

// ==== tb/tb_cspc_top.sv ====
// Testbench for the socket power control block.
// Assumes the socket model and the bound checker.
`timescale 1ns/100ps
module tb_cspc_top;
    import cspc_pkg::*;
    logic core_clk, rst_b, reg_wr, reg_rd, sysctrl_supply_gate, card_in, cd1_b, cd2_b, oe;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_r, int_gen_ctrl_r;
    cspc_pwr_t pwr;
    int n_fail = 0;
    int num_checks = 0;
    cspc_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .sysctrl_supply_gate(sysctrl_supply_gate), .card_detect1_b(cd1_b),
        .card_detect2_b(cd2_b), .card_output_enable_r(oe), .pwr_req_r(pwr),
        .int_gen_ctrl_r(int_gen_ctrl_r));
    cspc_socket_model u_sock (.card_in(card_in), .card_detect1_b(cd1_b), .card_detect2_b(cd2_b));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------------
    // Bus tasks and compare
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge core_clk);
        reg_rd = 1'h0;
        chk(reg_rdata_r, exp);
        @(negedge core_clk);
    endtask : rd
    task automatic pins(input logic g, input logic c, input logic [7:0] exp);
        sysctrl_supply_gate = g;
        card_in = c;
        repeat (2) @(negedge core_clk);
        chk({4'h0, pwr}, exp);
    endtask : pins
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(CSPC_OFS_ID_REV, CSPC_RST_ID_REV);
        rd(CSPC_OFS_POWER, 8'h00);
        rd(CSPC_OFS_INT_GEN, 8'h00);
        chk({7'h0, oe}, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ext;
        logic [7:0] ev [8] = '{8'h00, 8'h00, 8'h06, 8'h0A, 8'h04, 8'h05, 8'h06, 8'h04};
        wr(CSPC_OFS_POWER, 8'hFF);
        rd(CSPC_OFS_POWER, 8'h9B);
        chk({7'h0, oe}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(CSPC_OFS_POWER, (i < 4) ? {3'h0, i[1:0], 3'h2} : {6'h04, i[1:0]});
            chk({4'h0, pwr}, ev[i]);
        end
        chk({7'h0, oe}, 8'h00);
        $display("t_ext done");
    endtask : t_ext
    task automatic t_legacy;
        wr(CSPC_OFS_ID_REV, 8'hF2);
        rd(CSPC_OFS_ID_REV, 8'hB2);
        wr(CSPC_OFS_POWER, 8'hFF);
        rd(CSPC_OFS_POWER, 8'hB3);
        pins(1'b1, 1'b0, 8'h00);
        pins(1'b1, 1'b1, 8'h04);
        pins(1'b0, 1'b1, 8'h00);
        wr(CSPC_OFS_POWER, 8'h91);
        pins(1'b1, 1'b0, 8'h05);
        wr(CSPC_OFS_POWER, 8'h81);
        chk({4'h0, pwr}, 8'h00);
        wr(CSPC_OFS_ID_REV, 8'h03);
        wr(CSPC_OFS_POWER, 8'hFF);
        rd(CSPC_OFS_POWER, 8'h9B);
        $display("t_legacy done");
    endtask : t_legacy
    task automatic t_intgen;
        wr(CSPC_OFS_INT_GEN, 8'hA5);
        rd(CSPC_OFS_INT_GEN, 8'hA5);
        wr(CSPC_OFS_INT_GEN, 8'h5A);
        wr(12'h801, 8'hFF);
        rd(12'h801, 8'h00);
        rd(CSPC_OFS_INT_GEN, 8'h5A);
        chk(int_gen_ctrl_r, 8'h5A);
        $display("t_intgen done");
    endtask : t_intgen
    task automatic t_rerst;
        wr(CSPC_OFS_ID_REV, 8'h02);
        wr(CSPC_OFS_POWER, 8'h91);
        chk({pwr, 3'h0, oe}, 8'h51);
        rst_b = 1'h0;
        @(negedge core_clk);
        chk({pwr, 3'h0, oe}, 8'h00);
        chk(int_gen_ctrl_r, CSPC_RST_INT_GEN);
        rst_b = 1'h1;
        @(negedge core_clk);
        rd(CSPC_OFS_ID_REV, CSPC_RST_ID_REV);
        rd(CSPC_OFS_POWER, CSPC_RST_POWER);
        $display("t_rerst done");
    endtask : t_rerst
    task automatic summarize;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        sysctrl_supply_gate = 1'b0;
        card_in = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        t_reset();
        t_ext();
        t_legacy();
        t_intgen();
        t_rerst();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        summarize();
    end
endmodule : tb_cspc_top
